//--- common/bvm_pkg.sv
// Purpose: shared constants of the bus voltage monitor and alarm block
// Assumes: byte-wide register port, one 250 MHz clock
// Notes: offsets are the byte addresses of the register port

package bvm_pkg;

    // --------------------------------------------------------------
    // register offsets
    // --------------------------------------------------------------
    localparam logic [7:0] BVM_ADDR_MEAS_UPPER = 8'h71;
    localparam logic [7:0] BVM_ADDR_DISCH_LO = 8'h74;
    localparam logic [7:0] BVM_ADDR_DISCH_HI = 8'h75;
    localparam logic [7:0] BVM_ADDR_HIALM_LO = 8'h76;
    localparam logic [7:0] BVM_ADDR_HIALM_HI = 8'h77;
    localparam logic [7:0] BVM_ADDR_LOALM_LO = 8'h78;
    localparam logic [7:0] BVM_ADDR_LOALM_HI = 8'h79;
    localparam logic [7:0] BVM_ADDR_ALT_LO = 8'h7A;
    localparam logic [7:0] BVM_ADDR_ALT_HI = 8'h7B;

    // --------------------------------------------------------------
    // reset values and field layout
    // --------------------------------------------------------------
    localparam logic [7:0] BVM_RST_DISCH_LO = 8'h20;
    localparam logic [7:0] BVM_RST_ZERO = 8'h00;
    localparam logic [7:0] BVM_RD_UNMAPPED = 8'h00;
    localparam int BVM_MEAS_W = 10;
    localparam int BVM_UP_W = 2;
    localparam int BVM_SP_W = 11;
    localparam logic [1:0] BVM_SCALE_NONE = 2'h0;
    localparam logic [3:0] BVM_UPPER_PAD = 4'h0;

    // --------------------------------------------------------------
    // discharge level and setpoint codes
    // --------------------------------------------------------------
    localparam logic [9:0] BVM_DISCH_MASK = 10'h3FC;
    localparam logic [9:0] BVM_DISCH_RANGE_LO = 10'h01C;
    localparam logic [9:0] BVM_DISCH_FLOOR = 10'h014;
    localparam logic [10:0] BVM_SP_COARSE_MIN = 11'h0A5;
    localparam logic [10:0] BVM_SP_COARSE_MAX = 11'h3FF;
    localparam logic [10:0] BVM_SP_FINE_MIN = 11'h14A;
    localparam logic [10:0] BVM_SP_FINE_MAX = 11'h7FF;

    // --------------------------------------------------------------
    // timing
    // --------------------------------------------------------------
    localparam int BVM_CLK_PERIOD_PS = 4000;
    localparam int BVM_SLEW_STEP_NS = 100;
    localparam int BVM_SLEW_STEP_CYC = (BVM_SLEW_STEP_NS * 1000) / BVM_CLK_PERIOD_PS;
    localparam int BVM_TICK_W = 8;

endpackage

//--- core/bvm_level_alarm.sv
// Purpose: one level-triggered voltage alarm with a sticky flag
// Assumes: i_sample pulses once per new measurement
// Notes: instantiated once for the high and once for the low alarm

`timescale 1ns/1ps
`default_nettype none

module bvm_level_alarm #(
    parameter bit ABOVE = 1'b1
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset,
    // comparison
    input wire logic [bvm_pkg::BVM_MEAS_W-1:0] i_meas,
    input wire logic [bvm_pkg::BVM_MEAS_W-1:0] i_thresh,
    input wire logic i_sample,
    // flag control
    input wire logic i_disable,
    input wire logic i_clear,
    output logic o_flag
);
    import bvm_pkg::*;

    logic cond;
    wire beyond = ABOVE ? (i_meas > i_thresh) : (i_meas < i_thresh);
    // set wins over a clear in the same cycle, so a lasting level re-raises
    wire next_flag = (o_flag & ~i_clear) | (cond & ~i_disable);

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            cond <= 1'b0;
            o_flag <= 1'b0;
        end else begin
            if (i_sample) begin
                cond <= beyond;
            end
            o_flag <= next_flag;
        end
    end

    property p_flag_raise;
        @(posedge i_core_clk) disable iff (i_reset)
        (cond && !i_disable) |=> o_flag;
    endproperty
    a_flag_raise: assert property (p_flag_raise) else $error("alarm flag not raised");

    property p_reassert;
        @(posedge i_core_clk) disable iff (i_reset)
        (o_flag && i_clear && cond && !i_disable) |=> o_flag;
    endproperty
    a_reassert: assert property (p_reassert) else $error("flag lost while level persists");

endmodule

`default_nettype wire

//--- core/bvm_slew_step.sv
// Purpose: moves the driven setpoint one count per tick toward its target
// Assumes: i_tick is a one-cycle enable from a divider
// Notes: level is in fine setpoint units

`timescale 1ns/1ps
`default_nettype none

module bvm_slew_step (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset,
    // control
    input wire logic i_tick,
    input wire logic [bvm_pkg::BVM_SP_W-1:0] i_target,
    // state
    output logic [bvm_pkg::BVM_SP_W-1:0] o_level,
    output logic o_busy
);
    import bvm_pkg::*;

    wire go_up = i_target > o_level;
    wire go_down = i_target < o_level;
    wire [BVM_SP_W-1:0] next_level = go_up ? o_level + 11'h001 :
                                     go_down ? o_level - 11'h001 : o_level;

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_level <= '0;
            o_busy <= 1'b0;
        end else begin
            o_busy <= go_up | go_down;
            if (i_tick) begin
                o_level <= next_level;
            end
        end
    end

    property p_step_on_tick;
        @(posedge i_core_clk) disable iff (i_reset)
        !i_tick |=> $stable(o_level);
    endproperty
    a_step_on_tick: assert property (p_step_on_tick) else $error("level moved without tick");

endmodule

`default_nettype wire

//--- core/bvm_top.sv
// Purpose: supply voltage readout, discharge level, alarms, alternate setpoint
// Assumes: register port driven by the serial interface on the same clock
// Notes: measurement, enables and commands arrive from logic on this clock

`timescale 1ns/1ps
`default_nettype none

module bvm_top (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset,
    // register port
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    // measurement
    input wire logic [bvm_pkg::BVM_MEAS_W-1:0] i_adc_code,
    input wire logic i_adc_valid,
    input wire logic i_monitor_enable,
    // alarms
    input wire logic i_alarm_disable,
    input wire logic i_over_clear,
    input wire logic i_under_clear,
    output logic o_over_level_flag,
    output logic o_under_level_flag,
    // discharge
    output logic [bvm_pkg::BVM_MEAS_W-1:0] o_discharge_end_level,
    // alternate setpoint
    input wire logic i_fine_select,
    input wire logic i_drive_alt_cmd,
    output logic [bvm_pkg::BVM_SP_W-1:0] o_setpoint_target,
    output logic [bvm_pkg::BVM_SP_W-1:0] o_setpoint_level,
    output logic o_setpoint_range_err,
    output logic o_slewing
);
    import bvm_pkg::*;

    // --------------------------------------------------------------
    // register storage
    // --------------------------------------------------------------
    logic [7:0] disch_lo;
    logic [BVM_UP_W-1:0] disch_hi;
    logic [7:0] hialm_lo;
    logic [BVM_UP_W-1:0] hialm_hi;
    logic [7:0] loalm_lo;
    logic [BVM_UP_W-1:0] loalm_hi;
    logic [7:0] alt_lo;
    logic [7:0] alt_hi;
    logic [BVM_MEAS_W-1:0] meas;
    logic meas_new;
    logic [BVM_TICK_W-1:0] tick_cnt;
    logic slew_tick;

    // --------------------------------------------------------------
    // address decode
    // --------------------------------------------------------------
    wire wr_disch_lo = i_reg_wr && (i_reg_addr == BVM_ADDR_DISCH_LO);
    wire wr_disch_hi = i_reg_wr && (i_reg_addr == BVM_ADDR_DISCH_HI);
    wire wr_hialm_lo = i_reg_wr && (i_reg_addr == BVM_ADDR_HIALM_LO);
    wire wr_hialm_hi = i_reg_wr && (i_reg_addr == BVM_ADDR_HIALM_HI);
    wire wr_loalm_lo = i_reg_wr && (i_reg_addr == BVM_ADDR_LOALM_LO);
    wire wr_loalm_hi = i_reg_wr && (i_reg_addr == BVM_ADDR_LOALM_HI);
    wire wr_alt_lo = i_reg_wr && (i_reg_addr == BVM_ADDR_ALT_LO);
    wire wr_alt_hi = i_reg_wr && (i_reg_addr == BVM_ADDR_ALT_HI);

    // --------------------------------------------------------------
    // read selection
    // --------------------------------------------------------------
    // reserved bits read zero, scale code fixed at unscaled
    wire [7:0] rd_upper = {BVM_UPPER_PAD, BVM_SCALE_NONE, meas[9:8]};
    wire [7:0] rd_mux =
        (i_reg_addr == BVM_ADDR_MEAS_UPPER) ? rd_upper :
        (i_reg_addr == BVM_ADDR_DISCH_LO) ? disch_lo :
        (i_reg_addr == BVM_ADDR_DISCH_HI) ? {6'h00, disch_hi} :
        (i_reg_addr == BVM_ADDR_HIALM_LO) ? hialm_lo :
        (i_reg_addr == BVM_ADDR_HIALM_HI) ? {6'h00, hialm_hi} :
        (i_reg_addr == BVM_ADDR_LOALM_LO) ? loalm_lo :
        (i_reg_addr == BVM_ADDR_LOALM_HI) ? {6'h00, loalm_hi} :
        (i_reg_addr == BVM_ADDR_ALT_LO) ? alt_lo :
        (i_reg_addr == BVM_ADDR_ALT_HI) ? alt_hi :
        BVM_RD_UNMAPPED;

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_reg_rdata <= BVM_RD_UNMAPPED;
        end else if (i_reg_rd) begin
            o_reg_rdata <= rd_mux;
        end
    end

    // --------------------------------------------------------------
    // threshold and setpoint registers
    // --------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            disch_lo <= BVM_RST_DISCH_LO;
            disch_hi <= '0;
        end else begin
            if (wr_disch_lo) begin
                disch_lo <= i_reg_wdata;
            end
            if (wr_disch_hi) begin
                disch_hi <= i_reg_wdata[BVM_UP_W-1:0];
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            hialm_lo <= BVM_RST_ZERO;
            hialm_hi <= '0;
        end else begin
            if (wr_hialm_lo) begin
                hialm_lo <= i_reg_wdata;
            end
            if (wr_hialm_hi) begin
                hialm_hi <= i_reg_wdata[BVM_UP_W-1:0];
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            loalm_lo <= BVM_RST_ZERO;
            loalm_hi <= '0;
        end else begin
            if (wr_loalm_lo) begin
                loalm_lo <= i_reg_wdata;
            end
            if (wr_loalm_hi) begin
                loalm_hi <= i_reg_wdata[BVM_UP_W-1:0];
            end
        end
    end

    // writing only stores; nothing downstream moves until the command
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            alt_lo <= BVM_RST_ZERO;
            alt_hi <= BVM_RST_ZERO;
        end else begin
            if (wr_alt_lo) begin
                alt_lo <= i_reg_wdata;
            end
            if (wr_alt_hi) begin
                alt_hi <= i_reg_wdata;
            end
        end
    end

    // --------------------------------------------------------------
    // measurement capture
    // --------------------------------------------------------------
    // results are only trusted while the monitor runs
    wire take_meas = i_adc_valid && i_monitor_enable;

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            meas <= '0;
            meas_new <= 1'b0;
        end else begin
            meas_new <= take_meas;
            if (take_meas) begin
                meas <= i_adc_code;
            end
        end
    end

    // --------------------------------------------------------------
    // voltage alarms
    // --------------------------------------------------------------
    wire [BVM_MEAS_W-1:0] hi_level = {hialm_hi, hialm_lo};
    wire [BVM_MEAS_W-1:0] lo_level = {loalm_hi, loalm_lo};

    bvm_level_alarm #(
        .ABOVE(1'b1)
    ) u_over (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_meas(meas),
        .i_thresh(hi_level),
        .i_sample(meas_new),
        .i_disable(i_alarm_disable),
        .i_clear(i_over_clear),
        .o_flag(o_over_level_flag)
    );

    bvm_level_alarm #(
        .ABOVE(1'b0)
    ) u_under (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_meas(meas),
        .i_thresh(lo_level),
        .i_sample(meas_new),
        .i_disable(i_alarm_disable),
        .i_clear(i_under_clear),
        .o_flag(o_under_level_flag)
    );

    // --------------------------------------------------------------
    // discharge end level
    // --------------------------------------------------------------
    // low two bits dropped, small codes pinned to the 0.5 V floor
    wire [BVM_MEAS_W-1:0] disch_raw = {disch_hi, disch_lo};
    wire [BVM_MEAS_W-1:0] disch_masked = disch_raw & BVM_DISCH_MASK;
    wire disch_floor = disch_masked < BVM_DISCH_RANGE_LO;
    wire [BVM_MEAS_W-1:0] next_disch = disch_floor ? BVM_DISCH_FLOOR : disch_masked;

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_discharge_end_level <= BVM_DISCH_FLOOR;
        end else begin
            o_discharge_end_level <= next_disch;
        end
    end

    // --------------------------------------------------------------
    // alternate setpoint
    // --------------------------------------------------------------
    // coarse counts are twice the fine step, so the target is kept in fine units
    wire [15:0] alt_word = {alt_hi, alt_lo};
    wire [BVM_SP_W-1:0] coarse_code = {1'b0, alt_word[9:0]};
    wire [BVM_SP_W-1:0] fine_code = alt_word[10:0];
    wire [BVM_SP_W-1:0] sp_code = i_fine_select ? fine_code : coarse_code;
    wire [BVM_SP_W-1:0] sp_min = i_fine_select ? BVM_SP_FINE_MIN : BVM_SP_COARSE_MIN;
    wire [BVM_SP_W-1:0] sp_max = i_fine_select ? BVM_SP_FINE_MAX : BVM_SP_COARSE_MAX;
    wire sp_high_bits = i_fine_select ? (alt_word[15:11] != 5'h00) : (alt_word[15:10] != 6'h00);
    wire sp_bad = sp_high_bits || (sp_code < sp_min) || (sp_code > sp_max);
    // a bad code is clamped so the converter never leaves its range
    wire [BVM_SP_W-1:0] sp_clamped = (sp_high_bits || sp_code > sp_max) ? sp_max :
                                     (sp_code < sp_min) ? sp_min : sp_code;
    wire [BVM_SP_W-1:0] sp_fine_units = i_fine_select ? sp_clamped :
                                        {sp_clamped[BVM_SP_W-2:0], 1'b0};

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_setpoint_target <= '0;
            o_setpoint_range_err <= 1'b0;
        end else if (i_drive_alt_cmd) begin
            o_setpoint_target <= sp_fine_units;
            o_setpoint_range_err <= sp_bad;
        end
    end

    // --------------------------------------------------------------
    // slew rate divider
    // --------------------------------------------------------------
    wire tick_wrap = tick_cnt == BVM_TICK_W'(BVM_SLEW_STEP_CYC - 1);

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            tick_cnt <= '0;
            slew_tick <= 1'b0;
        end else begin
            tick_cnt <= tick_wrap ? '0 : tick_cnt + 8'h01;
            slew_tick <= tick_wrap;
        end
    end

    bvm_slew_step u_slew (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_tick(slew_tick),
        .i_target(o_setpoint_target),
        .o_level(o_setpoint_level),
        .o_busy(o_slewing)
    );

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    sequence s_upper_read;
        i_reg_rd && (i_reg_addr == BVM_ADDR_MEAS_UPPER);
    endsequence

    property p_upper_read;
        @(posedge i_core_clk) disable iff (i_reset)
        s_upper_read |=> (o_reg_rdata[1:0] == $past(meas[9:8]));
    endproperty
    a_upper_read: assert property (p_upper_read) else $error("upper readout wrong");

    property p_scale_zero;
        @(posedge i_core_clk) disable iff (i_reset)
        s_upper_read |=> (o_reg_rdata[7:2] == 6'h00);
    endproperty
    a_scale_zero: assert property (p_scale_zero) else $error("scale bits not zero");

    property p_meas_hold;
        @(posedge i_core_clk) disable iff (i_reset)
        !i_monitor_enable |=> $stable(meas);
    endproperty
    a_meas_hold: assert property (p_meas_hold) else $error("measurement taken while off");

    property p_disch_floor;
        @(posedge i_core_clk) disable iff (i_reset)
        (({disch_hi, disch_lo} & BVM_DISCH_MASK) < BVM_DISCH_RANGE_LO)
            |=> (o_discharge_end_level == BVM_DISCH_FLOOR);
    endproperty
    a_disch_floor: assert property (p_disch_floor) else $error("discharge floor wrong");

    property p_disch_scaled;
        @(posedge i_core_clk) disable iff (i_reset)
        (disch_raw >= BVM_DISCH_RANGE_LO)
            |=> (o_discharge_end_level == ($past(disch_raw) & BVM_DISCH_MASK));
    endproperty
    a_disch_scaled: assert property (p_disch_scaled) else $error("discharge level wrong");

    property p_alarm_off;
        @(posedge i_core_clk) disable iff (i_reset)
        (i_alarm_disable && !o_over_level_flag) |=> !o_over_level_flag;
    endproperty
    a_alarm_off: assert property (p_alarm_off) else $error("alarm raised while disabled");

    property p_store_only;
        @(posedge i_core_clk) disable iff (i_reset)
        !i_drive_alt_cmd |=> $stable(o_setpoint_target);
    endproperty
    a_store_only: assert property (p_store_only) else $error("target moved without command");

    sequence s_fine_cmd;
        i_drive_alt_cmd && i_fine_select && !sp_bad;
    endsequence

    property p_fine_target;
        @(posedge i_core_clk) disable iff (i_reset)
        s_fine_cmd |=> (o_setpoint_target == $past(alt_word[10:0]));
    endproperty
    a_fine_target: assert property (p_fine_target) else $error("fine target wrong");

    sequence s_coarse_cmd;
        i_drive_alt_cmd && !i_fine_select && !sp_bad;
    endsequence

    property p_coarse_target;
        @(posedge i_core_clk) disable iff (i_reset)
        s_coarse_cmd |=> (o_setpoint_target == {$past(alt_word[9:0]), 1'b0});
    endproperty
    a_coarse_target: assert property (p_coarse_target) else $error("coarse target wrong");

endmodule

`default_nettype wire

//--- testbench/bvm_host.sv
// Purpose: manager model that drives the byte register port
// Assumes: strobes launched 1 ns after the rising edge
// Notes: address and data are scrambled while no strobe is up
`timescale 1ns/1ps
`default_nettype none
module bvm_host (
    // clock
    input wire logic i_core_clk,
    // register port
    output logic [7:0] o_reg_addr,
    output logic o_reg_wr,
    output logic o_reg_rd,
    output logic [7:0] o_reg_wdata,
    input wire logic [7:0] i_reg_rdata
);
    initial begin
        o_reg_addr = 8'h00;
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_wdata = 8'h00;
    end
    // one byte access, write when w is one, read data taken at the same edge
    task automatic put(input logic [7:0] a, input logic [7:0] d, input logic w, output logic [7:0] q);
        @(posedge i_core_clk);
        #1;
        o_reg_addr = a;
        o_reg_wdata = d;
        o_reg_wr = w;
        o_reg_rd = !w;
        @(posedge i_core_clk);
        #1;
        q = i_reg_rdata;
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_addr = ~a;
        o_reg_wdata = ~d;
    endtask
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// Purpose: self-checking bench of the monitor and alarm block
// Assumes: inputs change 1 ns after the rising edge
// Notes: register image, flags and setpoint are modelled with integers
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import bvm_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [9:0] adc = 10'h000;
    logic adc_v = 1'b0, mon = 1'b1, dis = 1'b0, oclr = 1'b0, uclr = 1'b0, fine = 1'b0, drv = 1'b0;
    wire logic [7:0] addr, wdata, rdata;
    wire logic wr, rd, of, uf, err, slew;
    wire logic [9:0] disch;
    wire logic [10:0] tgt, lvl;
    int num_errors = 0, checks_done = 0, seed = 59, meas = 0, hi = 0, lo = 0, e = 0;
    logic om = 1'b0, um = 1'b0, em;
    logic [7:0] q;
    logic [7:0] regm [int];
    always #2 i_core_clk = ~i_core_clk;
    bvm_host host_u (.i_core_clk(i_core_clk), .o_reg_addr(addr), .o_reg_wr(wr), .o_reg_rd(rd),
        .o_reg_wdata(wdata), .i_reg_rdata(rdata));
    bvm_top dut_u (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_reg_addr(addr), .i_reg_wr(wr),
        .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_adc_code(adc), .i_adc_valid(adc_v),
        .i_monitor_enable(mon), .i_alarm_disable(dis), .i_over_clear(oclr), .i_under_clear(uclr),
        .o_over_level_flag(of), .o_under_level_flag(uf), .o_discharge_end_level(disch),
        .i_fine_select(fine), .i_drive_alt_cmd(drv), .o_setpoint_target(tgt), .o_setpoint_level(lvl),
        .o_setpoint_range_err(err), .o_slewing(slew));
    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    function automatic int rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed & 32'h7FFFFFFF;
    endfunction
    function automatic int sp_exp(input int w, input logic f, output logic x);
        int lb, ub, v;
        lb = f ? 32'h14A : 32'h0A5;
        ub = f ? 32'h7FF : 32'h3FF;
        x = (w < lb) || (w > ub);
        v = (w < lb) ? lb : (w > ub) ? ub : w;
        return f ? v : 2 * v;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask
    task automatic wr_b(input logic [7:0] a, input logic [7:0] d);
        if (a >= 8'h74 && a <= 8'h7B) regm[a] = (a inside {8'h75, 8'h77, 8'h79}) ? (d & 8'h03) : d;
        host_u.put(a, d, 1'b1, q);
    endtask
    task automatic rd_all();
        for (int a = 8'h70; a <= 8'h7C; a++) begin
            host_u.put(8'(a), 8'h00, 1'b0, q);
            e = (a == 8'h71) ? (meas >> 8) : regm.exists(a) ? regm[a] : 0;
            check(16'(q), 16'(e), "register read");
        end
    endtask
    task automatic flags();
        check(16'(of), 16'(om), "over flag");
        check(16'(uf), 16'(um), "under flag");
    endtask
    task automatic conv(input int c);
        adc = 10'(c);
        adc_v = 1'b1;
        tick(1);
        adc_v = 1'b0;
        if (mon) meas = c;
        if (!dis && mon) om |= meas > hi;
        if (!dis && mon) um |= meas < lo;
        tick(4);
        flags();
    endtask
    task automatic clr(input logic o, input logic u);
        oclr = o;
        uclr = u;
        tick(1);
        oclr = 1'b0;
        uclr = 1'b0;
        if (o) om = !dis && meas > hi;
        if (u) um = !dis && meas < lo;
        tick(2);
        flags();
    endtask
    task automatic cmd(input int w, input logic f);
        wr_b(8'h7A, 8'(w));
        wr_b(8'h7B, 8'(w >> 8));
        tick(2);
        check(16'(tgt), 16'(e), "target before command");
        fine = f;
        drv = 1'b1;
        tick(1);
        drv = 1'b0;
        tick(1);
        e = sp_exp(w, f, em);
        check(16'(tgt), 16'(e), "target");
        check(16'(err), 16'(em), "range error");
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // --------------------------------------------------------------
    // tests
    // --------------------------------------------------------------
    initial begin
        #200000;
        num_errors++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        end_of_test();
    end
    initial begin
        int dc [7] = '{0, 32'h018, 32'h019, 32'h01C, 32'h01D, 32'h021, 32'h3FF};
        for (int a = 8'h74; a <= 8'h7B; a++) regm[a] = (a == 8'h74) ? 8'h20 : 8'h00;
        tick(2);
        i_reset = 1'b0;
        rd_all();
        check(16'(disch), 16'h0020, "discharge reset level");
        $display("test reset done");
        dis = 1'b1;
        for (int a = 8'h70; a <= 8'h7C; a++) wr_b(8'(a), 8'(rnd()));
        rd_all();
        foreach (dc[i]) begin
            wr_b(8'h74, 8'(dc[i]));
            wr_b(8'h75, 8'(dc[i] >> 8));
            tick(2);
            e = ((dc[i] & 32'h3FC) < 32'h01C) ? 32'h014 : (dc[i] & 32'h3FC);
            check(16'(disch), 16'(e), "discharge level");
        end
        $display("test registers done");
        conv(rnd() % 1024);
        rd_all();
        mon = 1'b0;
        conv(~meas & 32'h3FF);
        rd_all();
        mon = 1'b1;
        $display("test measurement done");
        hi = 32'h200 + rnd() % 32'h100;
        lo = 32'h050 + rnd() % 32'h40;
        wr_b(8'h76, 8'(hi));
        wr_b(8'h77, 8'(hi >> 8));
        wr_b(8'h78, 8'(lo));
        wr_b(8'h79, 8'(lo >> 8));
        // refresh both comparisons against the new levels before alarms go live
        conv(hi);
        dis = 1'b0;
        conv(hi);
        conv(hi + 1);
        clr(1'b1, 1'b0);
        dis = 1'b1;
        clr(1'b1, 1'b0);
        conv(hi + 5);
        dis = 1'b0;
        // a level that still stands raises its flag as soon as alarms are enabled again
        om |= meas > hi;
        um |= meas < lo;
        conv(lo);
        conv(lo - 1);
        clr(1'b0, 1'b1);
        conv(lo + 1);
        clr(1'b0, 1'b1);
        $display("test alarms done");
        e = 0;
        cmd(32'h0A5 + rnd() % 8, 1'b0);
        tick(1);
        check(16'(slew), 16'h0001, "slewing");
        for (int n = 0; n < 12000 && slew !== 1'b0; n++) tick(1);
        check(16'(lvl), 16'(tgt), "settled level");
        cmd(32'h150, 1'b1);
        cmd(32'h010, 1'b0);
        cmd(32'h400, 1'b0);
        cmd(32'h800, 1'b1);
        cmd(32'h100, 1'b1);
        $display("test setpoint done");
        end_of_test();
    end
endmodule
`default_nettype wire
